//--- par_to_ser_conversion_fifo.sv
// Purpose: 4096 x 9 FIFO with parallel write, load/shift output register and serial input.
// Assumes: Write side on ref_clk_in; read side on output_port_clock_in, unrelated in phase.
// Notes: Full, half and near-boundary flags follow the write clock; empty follows the read clock.
`timescale 1ns/1ns
module par_to_ser_conversion_fifo import pf_pkg::*; #(
    parameter int DW = PF_DATA_BITS,
    parameter int AW = PF_ADDR_BITS
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic pointer_clear_n_in,
    input wire logic write_enable_a_in,
    input wire logic write_enable_b_in,
    input wire logic [DW-1:0] write_data_in,
    input wire logic output_port_clock_in,
    input wire logic read_enable_in,
    input wire logic load_or_shift_select_in,
    input wire logic serial_in,
    output logic [DW-1:0] read_data_out,
    output logic storage_full_n_out,
    output logic half_level_n_out,
    output logic near_boundary_n_out,
    output logic nothing_stored_n_out
);
    localparam int DEPTH = 1 << AW;
    localparam logic [AW:0] DEPTH_CNT = DEPTH[AW:0];
    localparam logic [AW:0] HALF_CNT = DEPTH_CNT >> 1;
    localparam logic [AW:0] NEAR_CNT = PF_NEAR_GAP[AW:0];
    localparam logic [AW:0] ONE_CNT = {{AW{1'b0}}, 1'b1};
    localparam logic [AW:0] ZERO_CNT = '0;

    // ---- Reset distribution ----
    logic wr_clr_sync;
    logic wr_rst;
    logic wr_rst_q;
    logic rd_rst;

    // Clear releases after two write edges; rst_in is already on this clock
    pf_sync2 #(.W(1), .INIT(PF_RESET_ON)) u_wr_clr_sync (
        .clk_in(ref_clk_in),
        .clear_n_in(pointer_clear_n_in),
        .d_in(PF_RESET_OFF),
        .q_out(wr_clr_sync)
    );
    assign wr_rst = rst_in | wr_clr_sync;

    // Registered copy keeps the read side synchroniser fed from a flop
    always_ff @(posedge ref_clk_in or negedge pointer_clear_n_in) begin
        if (!pointer_clear_n_in) begin
            wr_rst_q <= PF_RESET_ON;
        end else begin
            wr_rst_q <= wr_rst;
        end
    end

    // Read side sees either reset after two read edges; clear still acts at once
    pf_sync2 #(.W(1), .INIT(PF_RESET_ON)) u_rd_rst_sync (
        .clk_in(output_port_clock_in),
        .clear_n_in(pointer_clear_n_in),
        .d_in(wr_rst_q),
        .q_out(rd_rst)
    );

    // ---- Write side ----
    logic [AW:0] wr_ptr;
    logic [AW:0] wr_gray;
    logic [AW:0] rd_gray_w;
    logic [AW:0] rd_ptr_w;
    logic [AW:0] wr_count;
    logic wr_take;
    logic [AW:0] next_wr_ptr;
    logic next_full_n;
    logic next_half_n;
    logic next_near_n;

    // A write needs both enables high at the rising edge; flags do not gate it
    assign wr_take = write_enable_a_in & write_enable_b_in & ~wr_rst;
    assign next_wr_ptr = wr_take ? wr_ptr + ONE_CNT : wr_ptr;

    // Pointer carries one extra bit so full and empty differ after wrap
    always_ff @(posedge ref_clk_in or negedge pointer_clear_n_in) begin
        if (!pointer_clear_n_in) begin
            wr_ptr <= '0;
            wr_gray <= '0;
        end else if (wr_rst) begin
            wr_ptr <= '0;
            wr_gray <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            wr_gray <= next_wr_ptr ^ (next_wr_ptr >> 1);
        end
    end

    // Read pointer crosses as gray code so only one bit moves per step
    pf_sync2 #(.W(AW + 1), .INIT('0)) u_rd_ptr_sync (
        .clk_in(ref_clk_in),
        .clear_n_in(pointer_clear_n_in),
        .d_in(rd_gray),
        .q_out(rd_gray_w)
    );

    // Fill level as seen by the writer; it lags reads by the crossing delay
    assign wr_count = wr_ptr - rd_ptr_w;
    assign next_full_n = (wr_count == DEPTH_CNT) ? PF_FLAG_ON : PF_FLAG_IDLE;
    assign next_half_n = (wr_count > HALF_CNT) ? PF_FLAG_ON : PF_FLAG_IDLE;
    assign next_near_n = ((wr_count < NEAR_CNT) || ((DEPTH_CNT - wr_count) < NEAR_CNT)) ? PF_FLAG_ON : PF_FLAG_IDLE;

    // Writer-side flags are registered on the write clock
    always_ff @(posedge ref_clk_in or negedge pointer_clear_n_in) begin
        if (!pointer_clear_n_in) begin
            storage_full_n_out <= PF_FLAG_IDLE;
            half_level_n_out <= PF_FLAG_IDLE;
            near_boundary_n_out <= PF_FLAG_ON;
        end else if (wr_rst) begin
            storage_full_n_out <= PF_FLAG_IDLE;
            half_level_n_out <= PF_FLAG_IDLE;
            near_boundary_n_out <= PF_FLAG_ON;
        end else begin
            storage_full_n_out <= next_full_n;
            half_level_n_out <= next_half_n;
            near_boundary_n_out <= next_near_n;
        end
    end

    // ---- Read side ----
    logic [AW:0] rd_ptr;
    logic [AW:0] rd_gray;
    logic [AW:0] wr_gray_r;
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_count;
    logic rd_load;
    logic rd_shift;
    logic [AW:0] next_rd_ptr;
    logic [AW-1:0] mem_rd_addr;
    logic [DW-1:0] mem_q;
    logic [DW-1:0] next_read_data;
    logic next_empty_n;

    // Select is sampled with the read enable on the read clock edge
    assign rd_load = read_enable_in & (load_or_shift_select_in == PF_LOAD_SEL) & ~rd_rst;
    assign rd_shift = read_enable_in & (load_or_shift_select_in != PF_LOAD_SEL) & ~rd_rst;
    assign next_rd_ptr = rd_rst ? ZERO_CNT : (rd_load ? rd_ptr + ONE_CNT : rd_ptr);

    // Memory is addressed one step ahead so the word is ready at the next load
    assign mem_rd_addr = next_rd_ptr[AW-1:0];

    // Read pointer advances only on a load; shifting reuses the held word
    always_ff @(posedge output_port_clock_in or negedge pointer_clear_n_in) begin
        if (!pointer_clear_n_in) begin
            rd_ptr <= '0;
            rd_gray <= '0;
        end else begin
            rd_ptr <= next_rd_ptr;
            rd_gray <= next_rd_ptr ^ (next_rd_ptr >> 1);
        end
    end

    // Write pointer crosses into the read domain in gray code; clocks need no relation
    pf_sync2 #(.W(AW + 1), .INIT('0)) u_wr_ptr_sync (
        .clk_in(output_port_clock_in),
        .clear_n_in(pointer_clear_n_in),
        .d_in(wr_gray),
        .q_out(wr_gray_r)
    );

    // Gray to binary for both crossed pointers, one bit per loop pass
    genvar gi;
    generate
        for (gi = 0; gi <= AW; gi++) begin : g_gray2bin
            assign rd_ptr_w[gi] = ^rd_gray_w[AW:gi];
            assign wr_ptr_r[gi] = ^wr_gray_r[AW:gi];
        end
    endgenerate

    // One parallel word in, one parallel word out per transfer
    pf_store_ram #(.DW(DW), .AW(AW)) u_store (
        .wr_clk_in(ref_clk_in),
        .wr_en_in(wr_take),
        .wr_addr_in(wr_ptr[AW-1:0]),
        .wr_data_in(write_data_in),
        .rd_clk_in(output_port_clock_in),
        .rd_addr_in(mem_rd_addr),
        .rd_data_out(mem_q)
    );

    // Shift feeds the serial input at the top, so chained parts form one long word
    // Identical parts given the same controls stay in step, so no glue is needed
    assign next_read_data = rd_load ? mem_q : (rd_shift ? {serial_in, read_data_out[DW-1:1]} : read_data_out);

    // Output register; bit 0 is the serial stream, since shifts move bits toward it
    always_ff @(posedge output_port_clock_in or negedge pointer_clear_n_in) begin
        if (!pointer_clear_n_in) begin
            read_data_out <= '0;
        end else if (rd_rst) begin
            read_data_out <= '0;
        end else begin
            read_data_out <= next_read_data;
        end
    end

    // Empty is judged against the crossed write pointer, so it clears late, never early
    assign rd_count = wr_ptr_r - rd_ptr;
    assign next_empty_n = (rd_count == ZERO_CNT) ? PF_FLAG_ON : PF_FLAG_IDLE;

    always_ff @(posedge output_port_clock_in or negedge pointer_clear_n_in) begin
        if (!pointer_clear_n_in) begin
            nothing_stored_n_out <= PF_FLAG_ON;
        end else if (rd_rst) begin
            nothing_stored_n_out <= PF_FLAG_ON;
        end else begin
            nothing_stored_n_out <= next_empty_n;
        end
    end

    // ---- Checks on the write clock ----
    property p_full_flag;
        @(posedge ref_clk_in) disable iff (wr_rst)
        (wr_count == DEPTH_CNT) |=> (storage_full_n_out == PF_FLAG_ON);
    endproperty
    a_full_flag: assert property (p_full_flag) else $error("full flag missing at full count");

    property p_half_flag;
        @(posedge ref_clk_in) disable iff (wr_rst)
        (wr_count > HALF_CNT) |=> (half_level_n_out == PF_FLAG_ON);
    endproperty
    a_half_flag: assert property (p_half_flag) else $error("half flag missing above half");

    property p_half_clear;
        @(posedge ref_clk_in) disable iff (wr_rst)
        (wr_count <= HALF_CNT) |=> (half_level_n_out == PF_FLAG_IDLE);
    endproperty
    a_half_clear: assert property (p_half_clear) else $error("half flag set at or below half");

    property p_near_flag;
        @(posedge ref_clk_in) disable iff (wr_rst)
        ((wr_count < NEAR_CNT) || ((DEPTH_CNT - wr_count) < NEAR_CNT)) |=> !near_boundary_n_out;
    endproperty
    a_near_flag: assert property (p_near_flag) else $error("near flag missing at boundary");

    property p_near_clear;
        @(posedge ref_clk_in) disable iff (wr_rst)
        ((wr_count >= NEAR_CNT) && ((DEPTH_CNT - wr_count) >= NEAR_CNT)) |=> near_boundary_n_out;
    endproperty
    a_near_clear: assert property (p_near_clear) else $error("near flag set away from boundary");

    property p_write_step;
        @(posedge ref_clk_in) disable iff (wr_rst)
        (write_enable_a_in && write_enable_b_in) |=> (wr_ptr == $past(wr_ptr) + ONE_CNT);
    endproperty
    a_write_step: assert property (p_write_step) else $error("write pointer did not advance");

    property p_write_hold;
        @(posedge ref_clk_in) disable iff (wr_rst)
        !(write_enable_a_in && write_enable_b_in) |=> $stable(wr_ptr);
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write without both enables");

    // Crossing is safe only while a single gray bit moves per write edge
    property p_wr_gray_step;
        @(posedge ref_clk_in) disable iff (wr_rst)
        $onehot0(wr_gray ^ $past(wr_gray));
    endproperty
    a_wr_gray_step: assert property (p_wr_gray_step) else $error("write gray pointer moved two bits");

    // ---- Checks on the read clock ----
    property p_shift_out;
        @(posedge output_port_clock_in) disable iff (rd_rst)
        (read_enable_in && (load_or_shift_select_in != PF_LOAD_SEL)) |=>
            (read_data_out == {$past(serial_in), $past(read_data_out[DW-1:1])}) && $stable(rd_ptr);
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("shift result wrong");

    property p_load_out;
        @(posedge output_port_clock_in) disable iff (rd_rst)
        (read_enable_in && (load_or_shift_select_in == PF_LOAD_SEL)) |=>
            (read_data_out == $past(mem_q)) && (rd_ptr == $past(rd_ptr) + ONE_CNT);
    endproperty
    a_load_out: assert property (p_load_out) else $error("load did not take stored word");

    property p_read_hold;
        @(posedge output_port_clock_in) disable iff (rd_rst)
        !read_enable_in |=> $stable(read_data_out) && $stable(rd_ptr);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("output changed without read enable");

    property p_empty_flag;
        @(posedge output_port_clock_in) disable iff (rd_rst)
        (rd_count == ZERO_CNT) |=> (nothing_stored_n_out == PF_FLAG_ON);
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("empty flag missing");

    property p_empty_clear;
        @(posedge output_port_clock_in) disable iff (rd_rst)
        (rd_count != ZERO_CNT) |=> (nothing_stored_n_out == PF_FLAG_IDLE);
    endproperty
    a_empty_clear: assert property (p_empty_clear) else $error("empty flag set while words held");

    property p_rd_gray_step;
        @(posedge output_port_clock_in) disable iff (rd_rst)
        $onehot0(rd_gray ^ $past(rd_gray));
    endproperty
    a_rd_gray_step: assert property (p_rd_gray_step) else $error("read gray pointer moved two bits");

    // Reset leaves zeroes in the output register until a load or a shift
    property p_clear_out;
        @(posedge output_port_clock_in)
        rd_rst |=> (read_data_out == '0);
    endproperty
    a_clear_out: assert property (p_clear_out) else $error("output not zero after reset");
endmodule

//--- pf_pkg.sv
// Purpose: Shared constants for the 4096 x 9 parallel-in, serial-capable FIFO.
// Assumes: Write side runs on ref_clk_in, read side on its own port clock.
// Notes: The near-boundary gap and the flag and reset levels live here; half and full follow from the depth.
package pf_pkg;
    localparam int PF_DATA_BITS = 9;
    localparam int PF_ADDR_BITS = 12;
    localparam int PF_NEAR_GAP = 8;
    localparam logic PF_FLAG_IDLE = 1'b1;
    localparam logic PF_FLAG_ON = 1'b0;
    localparam logic PF_LOAD_SEL = 1'b1;
    localparam logic PF_RESET_ON = 1'b1;
    localparam logic PF_RESET_OFF = 1'b0;
endpackage

//--- pf_sync2.sv
// Purpose: Two-flop synchroniser for a level or a gray-coded word.
// Assumes: At most one bit of d_in changes between destination edges.
// Notes: Clear is asynchronous and loads the constant INIT.
`timescale 1ns/1ns
module pf_sync2 import pf_pkg::*; #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic clear_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] stage1;

    // First stage is read only by the second to keep metastability contained
    always_ff @(posedge clk_in or negedge clear_n_in) begin
        if (!clear_n_in) begin
            stage1 <= INIT;
            q_out <= INIT;
        end else begin
            stage1 <= d_in;
            q_out <= stage1;
        end
    end
endmodule

//--- pf_store_ram.sv
// Purpose: Dual-clock storage array with a registered read port.
// Assumes: Write and read clocks are unrelated.
// Notes: Contents survive a pointer clear, so old words can be reread.
`timescale 1ns/1ns
module pf_store_ram import pf_pkg::*; #(
    parameter int DW = PF_DATA_BITS,
    parameter int AW = PF_ADDR_BITS
) (
    input wire logic wr_clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic rd_clk_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);
    logic [DW-1:0] cells [0:(1<<AW)-1];

    // Write side of the array
    always_ff @(posedge wr_clk_in) begin
        if (wr_en_in) begin
            cells[wr_addr_in] <= wr_data_in;
        end
    end

    // Read side; no reset so the array maps onto block memory
    always_ff @(posedge rd_clk_in) begin
        rd_data_out <= cells[rd_addr_in];
    end
endmodule

//--- pf_reader_model.sv
// Purpose: Reading-side model that owns the read clock and the read controls.
// Assumes: The bench calls rd to make one enabled read clock edge.
// Notes: Controls move on the falling read edge so they sit clear of sampling.
`timescale 1ns/1ns
module pf_reader_model (
    output logic port_clk_out,
    output logic ren_out,
    output logic sel_out,
    output logic si_out
);
    // Free-running read clock, phase unrelated to the write clock
    initial begin
        port_clk_out = 1'b0;
        #7;
        forever #15 port_clk_out = ~port_clk_out;
    end
    // Idle controls at time zero
    initial begin
        ren_out = 1'b0;
        sel_out = 1'b1;
        si_out = 1'b0;
    end
    // One enabled edge; this logic owns the enable, flags never drive it
    task automatic rd(input logic sel, input logic si);
        @(negedge port_clk_out);
        ren_out = 1'b1;
        sel_out = sel;
        si_out = si;
        @(negedge port_clk_out);
        ren_out = 1'b0;
        sel_out = ~sel; // Unused select flips so a stale level is not trusted
        si_out = ~si;
    endtask
endmodule

//--- par_to_ser_conversion_fifo_tb.sv
// Purpose: Self-checking bench for the 4096 x 9 FIFO with shifting output register.
// Assumes: Write side on ref_clk_in at 50 ns; read side from the reader model at 30 ns.
// Notes: Waits after bursts cover the flag crossing latency on both sides.
`timescale 1ns/1ns
module par_to_ser_conversion_fifo_tb import pf_pkg::*;;
    logic ref_clk_in;
    logic rst_in;
    logic pointer_clear_n_in;
    logic write_enable_a_in;
    logic write_enable_b_in;
    logic [8:0] write_data_in;
    logic [8:0] wd_next;
    logic [8:0] e;
    wire rd_clk;
    wire ren;
    wire sel;
    wire si;
    logic [8:0] q;
    logic full_n;
    logic half_n;
    logic near_n;
    logic empty_n;
    int fails;
    int cmp_count;
    int cyc;
    int n_tab[6] = '{8, 2040, 1, 2039, 1, 7};
    logic [2:0] f_tab[6] = '{3'b111, 3'b111, 3'b011, 3'b011, 3'b001, 3'b000};

    par_to_ser_conversion_fifo uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .pointer_clear_n_in(pointer_clear_n_in),
        .write_enable_a_in(write_enable_a_in), .write_enable_b_in(write_enable_b_in),
        .write_data_in(write_data_in), .output_port_clock_in(rd_clk), .read_enable_in(ren),
        .load_or_shift_select_in(sel), .serial_in(si), .read_data_out(q), .storage_full_n_out(full_n),
        .half_level_n_out(half_n), .near_boundary_n_out(near_n), .nothing_stored_n_out(empty_n));
    pf_reader_model rdr (.port_clk_out(rd_clk), .ren_out(ren), .sel_out(sel), .si_out(si));

    // Write clock, low at time zero
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    // Hang guard: the run needs well under half of this ceiling
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            close_out();
        end
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds enable a up across the burst, and enable b only when both is set, then lets both flag sides settle
    task automatic burst(input int n, input logic both);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk_in);
            write_enable_a_in = 1'b1; // clocks unrelated, so the full flag never drives it
            write_enable_b_in = both;
            write_data_in = wd_next;
            if (both) wd_next = wd_next + 9'h001;
        end
        @(negedge ref_clk_in);
        write_enable_a_in = 1'b0;
        write_enable_b_in = 1'b0;
        repeat (6) @(negedge ref_clk_in);
    endtask

    task automatic t_reset();
        chk(q, 9'h000);
        chk({5'h00, full_n, half_n, near_n, empty_n}, 9'h00c);
        $display("test reset done");
    endtask

    task automatic t_enables();
        burst(3, 1'b0);
        chk({8'h00, empty_n}, 9'h000);
        $display("test enables done");
    endtask

    task automatic t_order();
        burst(3, 1'b1);
        chk({8'h00, empty_n}, 9'h001);
        for (int k = 0; k < 3; k++) begin
            rdr.rd(1'b1, 1'b0);
            chk(q, 9'h101 + k[8:0]);
        end
        e = 9'h103;
        rdr.rd(1'b0, 1'b1);
        chk(q, {1'b1, e[8:1]});
        e = {1'b1, e[8:1]};
        rdr.rd(1'b0, 1'b0);
        chk(q, {1'b0, e[8:1]});
        e = {1'b0, e[8:1]};
        repeat (4) @(negedge rd_clk);
        chk(q, e);
        chk({8'h00, empty_n}, 9'h000);
        $display("test order and shift done");
    endtask

    // Count walks 8, 2048, 2049, 4088, 4089, 4096 as {half, near, full}
    task automatic t_levels();
        for (int i = 0; i < 6; i++) begin
            burst(n_tab[i], 1'b1);
            chk({6'h00, half_n, near_n, full_n}, {6'h00, f_tab[i]});
        end
        $display("test levels done");
    endtask

    // Clear acts with no clock edge; memory survives, so location zero reads again
    task automatic t_clear();
        @(negedge ref_clk_in);
        pointer_clear_n_in = 1'b0;
        #5;
        chk(q, 9'h000);
        chk({5'h00, full_n, half_n, near_n, empty_n}, 9'h00c);
        @(negedge ref_clk_in);
        pointer_clear_n_in = 1'b1;
        repeat (10) @(negedge ref_clk_in);
        rdr.rd(1'b1, 1'b0);
        chk(q, 9'h101);
        $display("test clear done");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        fails = 0;
        cmp_count = 0;
        cyc = 0;
        rst_in = 1'b1;
        pointer_clear_n_in = 1'b1;
        write_enable_a_in = 1'b0;
        write_enable_b_in = 1'b0;
        write_data_in = 9'h000;
        wd_next = 9'h101;
        repeat (20) @(negedge ref_clk_in);
        rst_in = 1'b0;
        repeat (10) @(negedge ref_clk_in);
        t_reset();
        t_enables();
        t_order();
        t_levels();
        t_clear();
        close_out();
    end
endmodule
